// [hw/fsps_seq.sv]
// Flash self-programming sequencer: holding buffer, unlock, timed operations
`default_nettype none
module fsps_seq
#(
   parameter int OSC_DIV = 34,
   parameter int ROW_CYCLES = fsps_pkg::ROW_WRITE_FRC_CYCLES
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic sys_rst_i,
   // Table access from the core
   input wire logic [7:0] table_page_pointer_i,
   input wire logic [15:0] effective_address_i,
   input wire logic table_write_low_word_i,
   input wire logic table_write_high_byte_i,
   input wire logic table_read_low_word_i,
   input wire logic table_read_high_byte_i,
   input wire logic byte_mode_i,
   input wire logic [15:0] wdata_i,
   output logic [15:0] rdata_o,
   output logic tbl_done_o,
   // Control and key writes
   input wire logic ctrl_we_i,
   input wire logic [15:0] ctrl_wdata_i,
   input wire logic key_we_i,
   input wire logic [7:0] key_wdata_i,
   output logic [15:0] flash_control_reg_o,
   // Core stall
   output logic stall_o,
   // Flash array side
   output logic [fsps_pkg::ADDR_W-1:0] flash_addr_o,
   output logic flash_erase_o,
   output logic flash_prog_o,
   output logic flash_row_o,
   output logic flash_cfg_space_o,
   output logic [23:0] flash_wdata_o,
   output logic [5:0] flash_buf_idx_o,
   input wire logic [23:0] flash_rdata_i
);
   import fsps_pkg::*;

   logic osc_tick;
   fsps_state_e state_reg, state_next;
   logic [15:0] lo_buf_reg [ROW_WORDS];
   logic [7:0] hi_buf_reg [ROW_WORDS];
   logic [ADDR_W-1:0] addr_reg;
   logic [1:0] key_reg;
   logic start_reg, enable_reg, erase_reg;
   logic [3:0] op_reg;
   logic [13:0] time_reg;
   logic tbl_busy_reg;
   logic [5:0] idx;
   logic [ADDR_W-1:0] tgt;
   logic launch;
   logic tbl_req;
   logic rd_lo_reg, rd_hi_reg, rd_bm_reg, rd_bsel_reg;

   fsps_osc_div #(.DIV(OSC_DIV)) u_div (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .tick_o(osc_tick)
   );

   // Full target address and row slot
   assign tgt = {table_page_pointer_i, effective_address_i};
   assign idx = tgt[6:1];
   // Any table instruction accepted this cycle
   assign tbl_req = (table_write_low_word_i || table_write_high_byte_i ||
                     table_read_low_word_i || table_read_high_byte_i) && !stall_o;

   // Table write into the holding buffer, byte lanes merged
   always_ff @(posedge clk_i) begin
      if (table_write_low_word_i && !stall_o) begin
         lo_buf_reg[idx] <= fsps_merge(lo_buf_reg[idx], wdata_i, byte_mode_i, tgt[0]);
      end
      if (table_write_high_byte_i && !stall_o && !(byte_mode_i && tgt[0])) begin
         hi_buf_reg[idx] <= wdata_i[7:0];
      end
   end

   // Latch address of last buffer write as operation target
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         addr_reg <= '0;
      end else if ((table_write_low_word_i || table_write_high_byte_i) && !stall_o) begin
         addr_reg <= tgt;
      end
   end

   // Table cycle timing: answer in second cycle
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         tbl_busy_reg <= 1'b0;
      end else begin
         tbl_busy_reg <= (table_write_low_word_i || table_write_high_byte_i ||
                          table_read_low_word_i || table_read_high_byte_i) &&
                         !stall_o && !tbl_busy_reg;
      end
   end
   assign tbl_done_o = tbl_busy_reg;

   // Pending table read: the array answers once the read address stands
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         rd_lo_reg <= 1'b0;
         rd_hi_reg <= 1'b0;
         rd_bm_reg <= 1'b0;
         rd_bsel_reg <= 1'b0;
      end else begin
         rd_lo_reg <= table_read_low_word_i && !stall_o;
         rd_hi_reg <= table_read_high_byte_i && !stall_o;
         rd_bm_reg <= byte_mode_i;
         rd_bsel_reg <= tgt[0];
      end
   end

   // Read data: low word, or high byte with zero phantom byte
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         rdata_o <= 16'h0000;
      end else if (rd_lo_reg) begin
         rdata_o <= rd_bm_reg ? {8'h00, (rd_bsel_reg ? flash_rdata_i[15:8] : flash_rdata_i[7:0])}
                              : flash_rdata_i[15:0];
      end else if (rd_hi_reg) begin
         rdata_o <= {8'h00, (rd_bm_reg && rd_bsel_reg) ? 8'h00 : flash_rdata_i[23:16]};
      end
   end

   // Unlock key tracker: 55h then AAh, cleared by any other key write or by a control write
   always_ff @(posedge clk_i) begin
      if (sys_rst_i || launch) begin
         key_reg <= 2'b00;
      end else if (key_we_i) begin
         if (key_wdata_i == KEY_FIRST) begin
            key_reg <= 2'b01;
         end else if (key_wdata_i == KEY_SECOND && key_reg == 2'b01) begin
            key_reg <= 2'b10;
         end else begin
            key_reg <= 2'b00;
         end
      end else if (ctrl_we_i) begin
         key_reg <= 2'b00;
      end
   end

   assign launch = ctrl_we_i && ctrl_wdata_i[CTRL_START_BIT] && !start_reg && key_reg == 2'b10 &&
                   ctrl_wdata_i[CTRL_ENABLE_BIT];

   // Control fields; start is hardware cleared
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         start_reg <= 1'b0;
         enable_reg <= 1'b0;
         erase_reg <= 1'b0;
         op_reg <= 4'h0;
      end else if (start_reg) begin
         if (state_reg != FSPS_IDLE && state_next == FSPS_IDLE) begin
            start_reg <= 1'b0;
         end
      end else if (ctrl_we_i) begin
         enable_reg <= ctrl_wdata_i[CTRL_ENABLE_BIT];
         erase_reg <= ctrl_wdata_i[CTRL_ERASE_BIT];
         op_reg <= ctrl_wdata_i[3:0];
         start_reg <= launch && state_next != FSPS_IDLE;
      end
   end
   assign flash_control_reg_o = {start_reg, enable_reg, 7'h00, erase_reg, 2'b00, op_reg};

   // Operation sequencer
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         FSPS_IDLE: begin
            if (launch) begin
               if (ctrl_wdata_i[CTRL_ERASE_BIT]) begin
                  state_next = FSPS_ERASE;
               end else if (ctrl_wdata_i[3:0] == OP_WORD) begin
                  state_next = FSPS_WORD;
               end else if (ctrl_wdata_i[3:0] == OP_ROW) begin
                  state_next = FSPS_ROW;
               end
            end
         end
         FSPS_ERASE, FSPS_ROW, FSPS_WORD: begin
            if (osc_tick && time_reg == 14'(ROW_CYCLES - 1)) begin
               state_next = FSPS_IDLE;
            end
         end
         default: state_next = FSPS_IDLE;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         state_reg <= FSPS_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // Oscillator cycle counter for the self-timed operation
   always_ff @(posedge clk_i) begin
      if (sys_rst_i || state_reg == FSPS_IDLE) begin
         time_reg <= 14'h0000;
      end else if (osc_tick) begin
         time_reg <= time_reg + 14'h0001;
      end
   end

   // Core stall during any operation
   assign stall_o = state_reg != FSPS_IDLE;

   // Flash array strobes; aligned addresses
   assign flash_erase_o = state_reg == FSPS_ERASE;
   assign flash_row_o = state_reg == FSPS_ROW;
   assign flash_prog_o = state_reg == FSPS_ROW || state_reg == FSPS_WORD;
   // Space select follows the address the array currently sees
   assign flash_cfg_space_o = flash_addr_o[ADDR_W-1];
   assign flash_buf_idx_o = (state_reg == FSPS_ROW) ? time_reg[5:0] : addr_reg[6:1];

   // Address aligned to page (1024 addr), row (128 addr, plus word slot) or word (2 addr)
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         flash_addr_o <= '0;
         flash_wdata_o <= 24'h000000;
      end else begin
         unique case (state_reg)
            FSPS_ERASE: flash_addr_o <= {addr_reg[ADDR_W-1:10], 10'h000};
            FSPS_ROW: flash_addr_o <= {addr_reg[ADDR_W-1:7], time_reg[5:0], 1'b0};
            FSPS_IDLE: flash_addr_o <= tbl_req ? {tgt[ADDR_W-1:1], 1'b0}
                                               : {addr_reg[ADDR_W-1:1], 1'b0};
            default: flash_addr_o <= {addr_reg[ADDR_W-1:1], 1'b0};
         endcase
         flash_wdata_o <= {hi_buf_reg[flash_buf_idx_o], lo_buf_reg[flash_buf_idx_o]};
      end
   end

   // Checks
   sequence s_unlocked;
      key_reg == 2'b10;
   endsequence
   AST_LOCKED_START: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (ctrl_we_i && ctrl_wdata_i[CTRL_START_BIT] && key_reg != 2'b10 && !stall_o)
      |=> !stall_o) else $error("start without unlock launched");
   AST_LAUNCH: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (s_unlocked ##0 (launch && ctrl_wdata_i[3:0] == OP_ROW && !ctrl_wdata_i[CTRL_ERASE_BIT]))
      |=> stall_o && flash_row_o) else $error("row program not launched");
   AST_STALL: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      stall_o |-> start_reg) else $error("stall without start bit");
   AST_CLEAR: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      $fell(stall_o) |-> !start_reg) else $error("start bit not cleared");
   AST_TBL: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (table_write_low_word_i && !stall_o && !tbl_busy_reg) |=> tbl_done_o)
      else $error("table write not two cycles");
   AST_NOKEY_AFTER: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      launch |=> key_reg == 2'b00) else $error("key not consumed");
   AST_TIME: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      stall_o |-> time_reg < 14'(ROW_CYCLES)) else $error("operation overran");
   AST_ERASE_ALIGN: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      $past(flash_erase_o) |-> flash_addr_o[9:0] == 10'h000)
      else $error("erase address not page aligned");
endmodule : fsps_seq
`default_nettype wire

// [hw/fsps_pkg.sv]
// Constants for the flash self-programming sequencer
`default_nettype none
package fsps_pkg;
   localparam int ROW_WORDS = 64;
   localparam int PAGE_ROWS = 8;
   localparam int PAGE_WORDS = 512;
   localparam int ROW_BYTES = 192;
   localparam int PAGE_BYTES = 1536;
   localparam int ROW_WRITE_FRC_CYCLES = 11064;
   localparam int PAGE_ERASE_FRC_CYCLES = 11064;
   localparam int WORD_WRITE_FRC_CYCLES = 11064;
   localparam int CTRL_START_BIT = 15;
   localparam int CTRL_ERASE_BIT = 6;
   localparam int CTRL_ENABLE_BIT = 14;
   localparam logic [7:0] KEY_FIRST = 8'h55;
   localparam logic [7:0] KEY_SECOND = 8'hAA;
   localparam logic [3:0] OP_WORD = 4'h3;
   localparam logic [3:0] OP_ROW = 4'h1;
   localparam logic [3:0] OP_PAGE = 4'h2;
   localparam int ADDR_W = 24;
   localparam int TBL_CYCLES = 2;
   typedef enum logic [3:0] {
      FSPS_IDLE  = 4'b0001,
      FSPS_ERASE = 4'b0010,
      FSPS_ROW   = 4'b0100,
      FSPS_WORD  = 4'b1000
   } fsps_state_e;
   // Byte-lane merge for word/byte table writes
   function automatic logic [15:0] fsps_merge(input logic [15:0] old_v, input logic [15:0] new_v,
                                              input logic byte_mode, input logic byte_sel);
      logic [15:0] r;
      r = new_v;
      if (byte_mode) begin
         r = byte_sel ? {new_v[7:0], old_v[7:0]} : {old_v[15:8], new_v[7:0]};
      end
      return r;
   endfunction
endpackage : fsps_pkg
`default_nettype wire

// [hw/fsps_osc_div.sv]
// Enable-pulse divider standing in for the fast RC oscillator tick
`default_nettype none
module fsps_osc_div #(
   parameter int DIV = 34
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic sys_rst_i,
   // Tick out
   output logic tick_o
);
   logic [7:0] cnt_reg;
   // Count clocks and pulse once per divide period
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         cnt_reg <= 8'h00;
         tick_o <= 1'b0;
      end else if (cnt_reg == 8'(DIV - 1)) begin
         cnt_reg <= 8'h00;
         tick_o <= 1'b1;
      end else begin
         cnt_reg <= cnt_reg + 8'h01;
         tick_o <= 1'b0;
      end
   end
endmodule : fsps_osc_div
`default_nettype wire

// [sim/fsps_flash_model.sv]
// Flash array model: address-patterned read data and an operation counter
`default_nettype none
module fsps_flash_model (
   // Clock and array controls
   input wire logic clk_i,
   input wire logic [23:0] addr_i,
   input wire logic prog_i,
   input wire logic erase_i,
   // Read data and operations seen
   output logic [23:0] rdata_o,
   output int ops_o = 0
);
   timeunit 1ns;
   timeprecision 1ps;
   logic busy_q = 1'b0;
   // Each word reads back a pattern of its own address, so a wrong address shows
   assign rdata_o = {addr_i[23:16] ^ addr_i[8:1], {addr_i[15:1], 1'b0} ^ 16'h3C96};
   // One count per array cycle, so a doubled or missing launch shows
   always @(posedge clk_i) begin
      busy_q <= prog_i | erase_i;
      if ((prog_i | erase_i) && !busy_q) ops_o <= ops_o + 1;
   end
endmodule // fsps_flash_model
`default_nettype wire

// [sim/flash_self_program_seq_tb.sv]
// Self-checking bench for the flash self-programming sequencer
`default_nettype none
module flash_self_program_seq_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import fsps_pkg::*;
   localparam int OD = 2;
   localparam int RUN = 8 * OD;
   typedef struct {int cyc; logic [15:0] exp; logic [15:0] msk; logic cfg;} fsps_note_s;
   logic clk_i = 1'b0, sys_rst_i = 1'b1;
   logic [7:0] pp = 8'h00, kd = 8'h00;
   logic [15:0] ea = 16'h0000, wd = 16'h0000, cd = 16'h0000, rdata, ctrl;
   logic twl = 0, twh = 0, trl = 0, trh = 0, bm = 0, cwe = 0, kwe = 0;
   logic done, stall, ferase, fprog, frow, fcfg;
   logic [23:0] faddr, frdata, pw, fwd, last_wa = 24'h000000;
   logic [5:0] fidx;
   logic [15:0] lo_exp[ROW_WORDS];
   logic [7:0] hi_exp[ROW_WORDS];
   logic [31:0] r, rng = 32'hC3DBA480;
   int ops, ops0, cycles = 0, miscompares = 0, checks_done = 0;
   fsps_note_s notes[$];
   fsps_seq #(.OSC_DIV(OD), .ROW_CYCLES(8)) uut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
      .table_page_pointer_i(pp), .effective_address_i(ea), .table_write_low_word_i(twl),
      .table_write_high_byte_i(twh), .table_read_low_word_i(trl),
      .table_read_high_byte_i(trh), .byte_mode_i(bm), .wdata_i(wd), .rdata_o(rdata),
      .tbl_done_o(done), .ctrl_we_i(cwe), .ctrl_wdata_i(cd), .key_we_i(kwe),
      .key_wdata_i(kd), .flash_control_reg_o(ctrl), .stall_o(stall), .flash_addr_o(faddr),
      .flash_erase_o(ferase), .flash_prog_o(fprog), .flash_row_o(frow),
      .flash_cfg_space_o(fcfg), .flash_wdata_o(fwd), .flash_buf_idx_o(fidx),
      .flash_rdata_i(frdata));
   fsps_flash_model fm (.clk_i(clk_i), .addr_i(faddr), .prog_i(fprog), .erase_i(ferase),
      .rdata_o(frdata), .ops_o(ops));
   // Clock
   initial forever #2 clk_i = ~clk_i;
   // Cycle count and hang limit
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 2000) begin
         miscompares++;
         print_verdict();
      end
   end
   function automatic logic [31:0] xs();
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      return rng;
   endfunction
   task automatic chk(input string n, input logic [23:0] s, input logic [23:0] e);
      checks_done++;
      if (s !== e) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // One table instruction; a note is queued when completion is expected
   task automatic tbl(input int k, input logic [7:0] p, input logic [15:0] a, input logic b,
                      input logic [15:0] d, input logic [15:0] e, input logic [15:0] m,
                      input logic nt);
      @(posedge clk_i);
      if (nt) notes.push_back('{cycles + 2, e, m, p[7]});
      pp <= p;
      ea <= a;
      bm <= b;
      wd <= d;
      {twl, twh, trl, trh} <= {k == 0, k == 1, k == 2, k == 3};
      @(posedge clk_i);
      {twl, twh, trl, trh} <= 4'h0;
   endtask
   // Two key writes then a control write, and the operation that should follow
   task automatic launch(input logic [7:0] k1, input logic [7:0] k2, input logic [15:0] c,
                         input logic [2:0] lv, input logic go);
      int d;
      ops0 = ops;
      @(posedge clk_i);
      kwe <= 1'b1;
      kd <= k1;
      @(posedge clk_i);
      kd <= k2;
      @(posedge clk_i);
      kwe <= 1'b0;
      cwe <= 1'b1;
      cd <= c;
      @(posedge clk_i);
      cwe <= 1'b0;
      @(posedge clk_i);
      #1;
      chk("stall", 24'(stall), 24'(go));
      chk("start bit", 24'(ctrl[15]), 24'(go));
      if (go) begin
         chk("op lines", 24'({ferase, fprog, frow}), 24'(lv));
         if (lv[2]) chk("erase target", faddr, last_wa & ~24'(2 * PAGE_WORDS - 1));
         else if (lv[0]) chk("row target", faddr, last_wa & ~24'(2 * ROW_WORDS - 1));
         else chk("word target", faddr, last_wa);
         if (lv == 3'b011) chk("row data", fwd, {hi_exp[0], lo_exp[0]});
         if (lv == 3'b010) chk("word slot", 24'(fidx), 24'(last_wa[6:1]));
         if (lv == 3'b010) chk("word data", fwd, {hi_exp[last_wa[6:1]], lo_exp[last_wa[6:1]]});
         tbl(0, 8'h00, 16'h0000, 0, 16'hFFFF, 0, 0, 0);
         #1;
         d = 3;
         while (stall === 1'b1 && d < 200) begin
            @(posedge clk_i);
            #1;
            d++;
         end
         chk("run length", 24'(d >= RUN - OD + 1 && d <= RUN + 1), 24'h1);
         chk("start cleared", 24'(ctrl), 24'(c & 16'h7FFF));
         chk("one operation", 24'(ops - ops0), 24'h1);
      end else begin
         repeat (RUN) @(posedge clk_i);
         #1;
         chk("no operation", 24'(ops - ops0), 24'h0);
      end
   endtask
   // Watcher: each completion takes the oldest note and compares against it
   initial begin : mon
      fsps_note_s n;
      forever begin
         @(posedge clk_i);
         #1;
         if (done === 1'b1) begin
            if (notes.size() == 0) chk("unexpected done", 24'h1, 24'h0);
            else begin
               n = notes.pop_front();
               chk("done cycle", 24'(cycles), 24'(n.cyc));
               chk("cfg space", 24'(fcfg), 24'(n.cfg));
               @(posedge clk_i);
               #1;
               chk("done width", 24'(done), 24'h0);
               chk("read data", 24'(rdata & n.msk), 24'(n.exp));
            end
         end
      end
   end
   // Main sequence
   initial begin
      repeat (6) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      @(posedge clk_i);
      #1;
      chk("reset outputs", 24'({stall, done, ctrl}), 24'h0);
      launch(8'h00, 8'h00, 16'hC001, 3'b000, 0);
      launch(KEY_SECOND, KEY_FIRST, 16'hC001, 3'b000, 0);
      for (int i = 0; i < ROW_WORDS; i++) begin
         r = xs();
         last_wa = {8'h01, 16'h0080 + 16'(2 * i)};
         lo_exp[i] = r[15:0];
         hi_exp[i] = r[23:16];
         tbl(0, 8'h01, 16'h0080 + 16'(2 * i), 0, r[15:0], 0, 0, 1);
         tbl(1, 8'h01, 16'h0080 + 16'(2 * i), 0, {8'h00, r[23:16]}, 0, 0, 1);
      end
      launch(KEY_FIRST, KEY_SECOND, 16'hC001, 3'b011, 1);
      launch(KEY_FIRST, KEY_SECOND, 16'hC003, 3'b010, 1);
      launch(KEY_FIRST, KEY_SECOND, 16'hC042, 3'b100, 1);
      for (int i = 0; i < 16; i++) begin
         r = xs();
         pw = {r[31:24] ^ r[8:1], {r[15:1], 1'b0} ^ 16'h3C96};
         if (i < 4) tbl(2, r[31:24], r[15:0], 0, 0, pw[15:0], 16'hFFFF, 1);
         else if (i < 8) tbl(3, r[31:24], r[15:0], 0, 0, {8'h00, pw[23:16]}, 16'hFFFF, 1);
         else if (i < 12) tbl(2, r[31:24], r[15:0], 1, 0,
                              {8'h00, r[0] ? pw[15:8] : pw[7:0]}, 16'h00FF, 1);
         else tbl(3, r[31:24], r[15:0], 1, 0,
                  {8'h00, r[0] ? 8'h00 : pw[23:16]}, 16'h00FF, 1);
      end
      repeat (4) @(posedge clk_i);
      #1;
      chk("notes left", 24'(notes.size()), 24'h0);
      print_verdict();
   end
endmodule // flash_self_program_seq_tb
`default_nettype wire
